//--- test_wti_timer.sv
// Self-checking bench for the watch and interval timer.
// Assumes wti_timer with a shortened clock divider; no partner model.
`timescale 1ns/1ns
`default_nettype none
`include "wti_consts.svh"

module test_wti_timer;
    localparam int PRE = 1;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic sub_clock = 1'b0;
    logic ien = 1'b0, wen = 1'b0, csel = 1'b0;
    logic [1:0] wsel = 2'h0;
    logic [2:0] isel = 3'h0;
    logic watch_irq, interval_irq;
    logic [`WTI_WATCH_CNT_W-1:0] watch_count;
    logic [`WTI_PRESCALER_W-1:0] prescaler_count;
    logic [7:0] watch_mode_reg;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int sub_cnt = 0;
    int seed = 32'h78f1;
    int n, r;

    wti_timer #(.PRE_DIV_LOG2(PRE)) u_wti_timer (.clock(clock), .reset_n(reset_n), .sub_clock(sub_clock),
        .interval_count_en(ien), .watch_count_en(wen), .watch_period_sel_lo(wsel[0]),
        .watch_period_sel_hi(wsel[1]), .interval_sel_b0(isel[0]), .interval_sel_b1(isel[1]),
        .interval_sel_b2(isel[2]), .watch_clock_sel(csel), .watch_irq(watch_irq),
        .interval_irq(interval_irq), .watch_count(watch_count), .prescaler_count(prescaler_count),
        .watch_mode_reg(watch_mode_reg));

    always #4 clock = ~clock;

    // Subsystem clock of 8 cycles, slow enough for the synchroniser
    always @(posedge clock) begin
        sub_cnt <= (sub_cnt + 1) % 8;
        sub_clock <= (sub_cnt >= 4);
    end

    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Guard sized for roughly 70k cycles of planned traffic
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares = compares + 1;
        if (exp !== seen) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input logic [31:0] seen);
        compares = compares + 1;
        if ($isunknown(seen) || !(seen >= lo && seen <= hi)) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask

    task automatic set_mode(input logic ie, input logic we, input logic [1:0] ws, input logic [2:0] is,
        input logic cs);
        @(posedge clock);
        ien <= ie;
        wen <= we;
        wsel <= ws;
        isel <= is;
        csel <= cs;
    endtask

    // Edges until the chosen interrupt is seen high
    task automatic wait_irq(input int sel, input int limit, output int cnt);
        cnt = 0;
        do begin
            @(posedge clock);
            cnt++;
        end while (((sel == 1) ? watch_irq : interval_irq) !== 1'b1 && cnt < limit);
    endtask

    // Model of the watch period in watch clocks
    function automatic int watch_ticks(input int ws);
        case (ws)
            0: return 2 ** 14;
            1: return 2 ** 13;
            2: return 2 ** 5;
            default: return 2 ** 4;
        endcase
    endfunction

    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check_val("mode", 8'h00, watch_mode_reg);
        check_val("irqs", 0, {watch_irq, interval_irq, watch_count, prescaler_count});
        for (int i = 0; i < 20; i++) begin
            r = $random(seed);
            set_mode(1'b0, 1'b0, r[1:0], r[4:2], r[5]);
            @(posedge clock);
            @(posedge clock);
            check_val("mode", {r[5], r[4:2], r[1:0], 2'b00}, watch_mode_reg);
            check_val("prescaler", 0, prescaler_count);
        end
        for (int c = 0; c < 8; c++) begin
            set_mode(1'b1, 1'b0, 2'h0, c[2:0], 1'b0);
            wait_irq(0, 9000, n);
            wait_irq(0, 9000, n);
            check_val("interval", (2 ** (c + 4)) * (2 ** PRE), n);
            @(posedge clock);
            check_val("interval_pulse", 0, interval_irq);
            set_mode(1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
        end
        set_mode(1'b1, 1'b0, 2'h0, 3'h0, 1'b1);
        wait_irq(0, 500, n);
        wait_irq(0, 500, n);
        check_val("sub_interval", 16 * 8, n);
        set_mode(1'b0, 1'b1, 2'h3, 3'h0, 1'b0);
        wait_irq(1, 200, n);
        check_val("watch_alone", 0, {watch_irq, watch_count});
        check_val("watch_alone_wait", 200, n);
        for (int w = 2; w < 4; w++) begin
            set_mode(1'b1, 1'b1, w[1:0], 3'h0, 1'b0);
            wait_irq(1, 200, n);
            wait_irq(1, 200, n);
            check_val("watch", watch_ticks(w) * (2 ** PRE), n);
            @(posedge clock);
            check_val("watch_pulse", 0, watch_irq);
            set_mode(1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
        end
        for (int w = 1; w >= 0; w--) begin
            set_mode(1'b1, 1'b1, w[1:0], 3'h0, 1'b0);
            wait_irq(1, 40000, n);
            check_range("watch_first", watch_ticks(w) * 2, watch_ticks(w) * 2 + 8, n);
            set_mode(1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
        end
        @(posedge clock);
        check_val("watch_cleared", 0, watch_count);
        set_mode(1'b1, 1'b1, 2'h0, 3'h0, 1'b0);
        repeat (1500) @(posedge clock);
        check_val("watch_count", 1, watch_count);
        set_mode(1'b1, 1'b0, 2'h0, 3'h0, 1'b0);
        repeat (3) @(posedge clock);
        check_val("zero_start", 0, watch_count);
        check_range("prescaler_kept", 740, 770, prescaler_count);
        set_mode(1'b1, 1'b1, 2'h0, 3'h0, 1'b0);
        // Next low-9-bit wrap comes about 273 ticks on, not 512
        repeat (600) @(posedge clock);
        check_val("early_step", 1, watch_count);
        set_mode(1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
        repeat (3) @(posedge clock);
        check_val("watch_stop", 0, {watch_count, prescaler_count});
        test_done();
    end
endmodule
`default_nettype wire

//--- wti_consts.svh
// Constants of the watch and interval timer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef WTI_CONSTS_SVH
`define WTI_CONSTS_SVH

// Mode register field positions and reset value
`define WTI_INTERVAL_EN_BIT 0
`define WTI_WATCH_EN_BIT 1
`define WTI_WATCH_SEL_LO 2
`define WTI_WATCH_SEL_HI 3
`define WTI_INTERVAL_SEL_LO 4
`define WTI_INTERVAL_SEL_HI 6
`define WTI_CLOCK_SEL_BIT 7
`define WTI_MODE_RESET 8'h00

// Counter structure
`define WTI_PRE_DIV_LOG2 7
`define WTI_PRESCALER_W 11
`define WTI_WATCH_CNT_W 5
`define WTI_WATCH_TAP 9
`define WTI_INTERVAL_MIN_LOG2 4

`endif

//--- wti_pkg.sv
// Types shared by the watch and interval timer.
// Assumes nothing of its surroundings.
`default_nettype none
package wti_pkg;
    typedef enum logic [1:0] {
        WTI_WATCH_P14 = 2'b00,
        WTI_WATCH_P13 = 2'b01,
        WTI_WATCH_P5 = 2'b10,
        WTI_WATCH_P4 = 2'b11
    } wti_watch_sel_t;
endpackage
`default_nettype wire

//--- wti_tick_gen.sv
// Watch clock enable: one pulse per watch clock period.
// Assumes the subsystem clock is an asynchronous pin, much slower than clock.
`timescale 1ns/1ns
`default_nettype none
`include "wti_consts.svh"

module wti_tick_gen #(
    parameter int PRE_DIV_LOG2 = `WTI_PRE_DIV_LOG2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sub_clock,
    input wire logic clock_sel,
    output logic tick
);
    logic [PRE_DIV_LOG2-1:0] div_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;

    generate
        if (PRE_DIV_LOG2 < 1 || PRE_DIV_LOG2 > 16) begin : g_chk
            $error("Prescale divider width out of range");
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // The second and third stages feed the edge detector
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= sub_clock;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tick <= 1'b0;
        end else if (clock_sel) begin
            tick <= sync2_reg & ~sync3_reg; // R6
        end else begin
            tick <= &div_reg; // R6
        end
    end
endmodule
`default_nettype wire

//--- wti_timer.sv
// Watch timer with interval timer on a shared 11-bit prescaler.
// Assumes mode bits come from logic on clock; subsystem clock is a raw pin.
//
// Operation
// R1: Watch interrupt repeats at a fixed interval from either clock source.
// R2: Watch counts only with both enables set; clearing zeroes the 5-bit counter.
// R3: Clearing only watch enable restarts watch from zero, interval keeps running.
// R4: Zero-second start leaves the prescaler running; first watch interrupt may be early.
// R5: Watch period select: 00=2^14, 01=2^13, 10=2^5, 11=2^4 watch clocks.
// R6: Clock select 1 uses subsystem clock, 0 uses clock divided by 128.
// R7: Software keeps mode bits 4 to 7 steady while counting.
// R8: Interval interrupt repeats each time the selected interval elapses.
// R9: Interval select in bits 4 to 6 picks 2^4 to 2^11 watch clocks.
// R10: Interval enable starts the prescaler; clearing it stops it.
// R11: Each interrupt is a single-cycle pulse at the counter overflow.
`timescale 1ns/1ns
`default_nettype none
`include "wti_consts.svh"

module wti_timer #(
    parameter int PRE_DIV_LOG2 = `WTI_PRE_DIV_LOG2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sub_clock,
    input wire logic interval_count_en,
    input wire logic watch_count_en,
    input wire logic watch_period_sel_lo,
    input wire logic watch_period_sel_hi,
    input wire logic interval_sel_b0,
    input wire logic interval_sel_b1,
    input wire logic interval_sel_b2,
    input wire logic watch_clock_sel,
    output logic watch_irq,
    output logic interval_irq,
    output logic [`WTI_WATCH_CNT_W-1:0] watch_count,
    output logic [`WTI_PRESCALER_W-1:0] prescaler_count,
    output logic [7:0] watch_mode_reg
);
    localparam int PW = `WTI_PRESCALER_W;
    localparam int IMIN = `WTI_INTERVAL_MIN_LOG2;

    // Top interval tap reads the whole prescaler, the watch tap its low bits
    generate
        if (PW < IMIN + 7 || PW < `WTI_WATCH_TAP) begin : g_chk
            $error("Prescaler too narrow for the interval and watch taps");
        end
    endgenerate

    logic tick;
    logic interval_run;
    logic watch_run;
    logic pre_wrap9;
    logic [7:0] interval_tap;
    wti_pkg::wti_watch_sel_t watch_sel;
    logic [2:0] interval_sel;
    logic watch_fire;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            watch_mode_reg <= `WTI_MODE_RESET;
        end else begin
            watch_mode_reg <= {watch_clock_sel, interval_sel_b2, interval_sel_b1, interval_sel_b0,
                               watch_period_sel_hi, watch_period_sel_lo, watch_count_en,
                               interval_count_en};
        end
    end

    assign interval_run = watch_mode_reg[`WTI_INTERVAL_EN_BIT];
    assign watch_run = interval_run & watch_mode_reg[`WTI_WATCH_EN_BIT]; // R2
    assign watch_sel = wti_pkg::wti_watch_sel_t'(watch_mode_reg[`WTI_WATCH_SEL_HI:`WTI_WATCH_SEL_LO]);
    assign interval_sel = watch_mode_reg[`WTI_INTERVAL_SEL_HI:`WTI_INTERVAL_SEL_LO];

    wti_tick_gen #(
        .PRE_DIV_LOG2(PRE_DIV_LOG2)
    ) u_tick (
        .clock(clock),
        .reset_n(reset_n),
        .sub_clock(sub_clock),
        .clock_sel(watch_mode_reg[`WTI_CLOCK_SEL_BIT]),
        .tick(tick)
    );

    // Prescaler ignores the watch enable so the interval timer is undisturbed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prescaler_count <= '0;
        end else if (!interval_run) begin
            prescaler_count <= '0; // R10
        end else if (tick) begin
            prescaler_count <= prescaler_count + 1'b1; // R4
        end
    end

    // One overflow tap per interval code, 2^4 up to 2^11
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_tap
            assign interval_tap[gi] = tick & (&prescaler_count[gi+IMIN-1:0]); // R9
        end
    endgenerate

    assign pre_wrap9 = tick & (&prescaler_count[`WTI_WATCH_TAP-1:0]);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            watch_count <= '0;
        end else if (!watch_run) begin
            watch_count <= '0; // R3
        end else if (pre_wrap9) begin
            watch_count <= watch_count + 1'b1; // R1
        end
    end

    always_comb begin
        case (watch_sel)
            wti_pkg::WTI_WATCH_P14: watch_fire = pre_wrap9 & (&watch_count); // R5
            wti_pkg::WTI_WATCH_P13: watch_fire = pre_wrap9 & (&watch_count[3:0]); // R5
            wti_pkg::WTI_WATCH_P5: watch_fire = interval_tap[1]; // R5
            wti_pkg::WTI_WATCH_P4: watch_fire = interval_tap[0]; // R5
            default: watch_fire = 1'b0;
        endcase
    end

    // Gated by watch_run again: the short periods use taps that run without it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            watch_irq <= 1'b0;
        end else begin
            watch_irq <= watch_run & watch_fire; // R11
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            interval_irq <= 1'b0;
        end else begin
            interval_irq <= interval_run & interval_tap[interval_sel]; // R8
        end
    end

    watch_pulse_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
        watch_irq |=> !watch_irq)
        else $error("Watch interrupt longer than one cycle");

    interval_pulse_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
        interval_irq |=> !interval_irq)
        else $error("Interval interrupt longer than one cycle");

    watch_stop_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        !watch_run |=> watch_count == '0)
        else $error("Watch counter not cleared when stopped");

    interval_stop_a: assert property (@(posedge clock) disable iff (!reset_n) // R10
        !interval_run |=> prescaler_count == '0 && !interval_irq)
        else $error("Prescaler running while interval disabled");

    prescaler_keep_a: assert property (@(posedge clock) disable iff (!reset_n) // R4
        interval_run && tick |=> prescaler_count == $past(prescaler_count) + 1'b1)
        else $error("Prescaler disturbed during count");

    interval_phase_a: assert property (@(posedge clock) disable iff (!reset_n) // R9
        interval_irq && $stable(interval_sel) |-> prescaler_count[3:0] == 4'h0 &&
            ((prescaler_count >> (4'(interval_sel) + 4'h4)) << (4'(interval_sel) + 4'h4)) == prescaler_count)
        else $error("Interval interrupt off its period");

    watch_long_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        watch_irq && watch_sel == wti_pkg::WTI_WATCH_P14 && $stable(watch_mode_reg)
            |-> watch_count == '0 && prescaler_count[8:0] == 9'h000)
        else $error("Watch period 2^14 misaligned");

    watch_short_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        watch_irq && watch_sel == wti_pkg::WTI_WATCH_P4 && $stable(watch_mode_reg)
            |-> prescaler_count[3:0] == 4'h0)
        else $error("Watch period 2^4 misaligned");

    watch_cause_a: assert property (@(posedge clock) disable iff (!reset_n) // R1
        watch_irq |-> $past(watch_run) && $past(tick))
        else $error("Watch interrupt without a watch clock tick");

    tick_div_a: assert property (@(posedge clock) disable iff (!reset_n) // R6
        tick && !watch_mode_reg[`WTI_CLOCK_SEL_BIT] && $stable(watch_mode_reg) |=> !tick)
        else $error("Divided watch clock tick too wide");

    tick_sub_a: assert property (@(posedge clock) disable iff (!reset_n) // R6
        tick && watch_mode_reg[`WTI_CLOCK_SEL_BIT] && $stable(watch_mode_reg) |=> !tick)
        else $error("Subsystem clock tick too wide");

    // Between ticks both counters must hold their value
    interval_hold_a: assert property (@(posedge clock) disable iff (!reset_n) // R10
        interval_run && !tick |=> prescaler_count == $past(prescaler_count))
        else $error("Prescaler moved without a tick");

    watch_hold_a: assert property (@(posedge clock) disable iff (!reset_n) // R1
        watch_run && !pre_wrap9 |=> watch_count == $past(watch_count))
        else $error("Watch counter moved without a prescaler wrap");

    watch_step_a: assert property (@(posedge clock) disable iff (!reset_n) // R1
        watch_run && pre_wrap9 |=> watch_count == $past(watch_count) + 1'b1)
        else $error("Watch counter missed a prescaler wrap");

    // Zero-second start: watch held at zero while the prescaler still steps
    zero_start_a: assert property (@(posedge clock) disable iff (!reset_n) // R3
        interval_run && !watch_mode_reg[`WTI_WATCH_EN_BIT] && tick
            |=> watch_count == '0 && prescaler_count == $past(prescaler_count) + 1'b1)
        else $error("Zero-second start disturbed the interval timer");

    watch_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        !watch_run |=> !watch_irq)
        else $error("Watch interrupt while watch stopped");

    interval_fire_a: assert property (@(posedge clock) disable iff (!reset_n) // R8
        interval_run && interval_tap[interval_sel] |=> interval_irq)
        else $error("Interval interrupt missed at its tap");

    watch_mid_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        watch_irq && watch_sel == wti_pkg::WTI_WATCH_P13 && $stable(watch_mode_reg)
            |-> watch_count[3:0] == 4'h0 && prescaler_count[8:0] == 9'h000)
        else $error("Watch period 2^13 misaligned");

    watch_fast_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        watch_irq && watch_sel == wti_pkg::WTI_WATCH_P5 && $stable(watch_mode_reg)
            |-> prescaler_count[4:0] == 5'h00)
        else $error("Watch period 2^5 misaligned");
endmodule
`default_nettype wire
